//--- design/link_interrupt_event_sources.sv
/*
 * Link interrupt event sources: sticky event bits 22..15 and 9..8, the
 * isochronous receive summary bit 7, per-context receive events and masks,
 * the interrupt mask with master enable, and an APB slave for all of them.
 * Assumes event sources are asynchronous levels from the link side and
 * that link_clock_ok is high while the PHY-supplied clock runs.
 */
// The APB slave port was left to the implementer.
// Overview of operation
// (R1) No cycle start between boundaries: lost cycle
// (R2) Predict lost cycle from gaps without start
// (R3) Seconds counter bit toggle sets 64-second event
// (R4) Cycle count LSB toggle sets boundary event
// (R5) PHY status request sets PHY event
// (R6) Failed access sets failure bit before next
// (R7) PHY bus reset entry sets bus reset
// (R8) Self-ID done sets; bus reset clears it
// (R9) Secondary self-ID follows primary, ignores reset
// (R10) Bits 14 to 10 read zero
// (R11) Lock response without ack sets error
// (R12) Host bus error on posted write sets
// (R13) Summary bit is masked OR, unlatched
// (R14) One event bit per receive context
// (R15) Set on edge or set write; clear-write clears
// (R16) Event read returns event AND mask
// (R17) Interrupt needs master enable and unmasked event
// (R18) Bounded wait for link clock on access
`timescale 1ns/10ps
`default_nettype none
module link_interrupt_event_sources
   import link_irq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cycle_count_lsb,
   input wire logic cycle_seconds_bit6,
   input wire logic cycle_start_seen,
   input wire logic subaction_gap,
   input wire logic arb_reset_gap,
   input wire logic phy_interrupt_request,
   input wire logic phy_bus_reset,
   input wire logic selfid_stream_done,
   input wire logic lock_response_no_ack,
   input wire logic posted_write_bus_error,
   input wire logic link_clock_ok,
   input wire logic [ISO_RX_CONTEXTS-1:0] iso_receive_context_event,
   output logic interrupt
);

   typedef enum logic [1:0] {CY_IDLE, CY_WAIT, CY_GAP, CY_MET} cycle_e;
   typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} bus_e;

   logic [SRC_COUNT-1:0] src;
   logic [SRC_COUNT-1:0] sync1;
   logic [SRC_COUNT-1:0] sync2;
   logic [SRC_COUNT-1:0] sync3;
   logic [SRC_COUNT-1:0] stable;
   logic [SRC_COUNT-1:0] rise;
   logic [SRC_COUNT-1:0] toggle;
   logic [31:0] event_bits;
   logic [31:0] mask_bits;
   logic [ISO_RX_CONTEXTS-1:0] iso_event;
   logic [ISO_RX_CONTEXTS-1:0] iso_mask;
   logic iso_receive_summary;
   logic [31:0] event_view;
   logic [31:0] hw_set;
   logic [31:0] hw_clear;
   cycle_e cycle_state;
   bus_e bus_state;
   logic [7:0] wait_count;
   logic access_fail;
   logic access_done;
   logic write_ok;
   logic [7:0] offset;
   logic mapped;
   logic [31:0] read_value;
   logic lost_cycle_hit;
   logic wr_event_set;
   logic wr_event_clear;
   logic wr_mask_set;
   logic wr_mask_clear;
   logic wr_iso_event_set;
   logic wr_iso_event_clear;
   logic wr_iso_mask_set;
   logic wr_iso_mask_clear;
   logic [31:0] sw_set;
   logic [31:0] sw_clear;
   logic [ISO_RX_CONTEXTS-1:0] iso_sw_set;
   logic [ISO_RX_CONTEXTS-1:0] iso_sw_clear;
   logic timed_out;

   assign src = {iso_receive_context_event, link_clock_ok,
      posted_write_bus_error, lock_response_no_ack, selfid_stream_done,
      phy_bus_reset, phy_interrupt_request, arb_reset_gap, subaction_gap,
      cycle_start_seen, cycle_seconds_bit6, cycle_count_lsb};

   // Three-stage synchronisers with agreement filter
   genvar g;
   generate
      for (g = 0; g < SRC_COUNT; g++) begin : gen_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1[g] <= 1'b0;
               sync2[g] <= 1'b0;
               sync3[g] <= 1'b0;
               stable[g] <= 1'b0;
            end else begin
               sync1[g] <= src[g];
               sync2[g] <= sync1[g];
               sync3[g] <= sync2[g];
               if (sync2[g] == sync3[g]) begin
                  stable[g] <= sync3[g];
               end
            end
         end
         assign toggle[g] = (sync2[g] == sync3[g]) && (sync3[g] != stable[g]);
         assign rise[g] = toggle[g] && sync3[g];
      end
   endgenerate

   // APB decode
   assign offset = paddr[7:0];
   assign mapped = (paddr[31:8] == 24'h000000) && (
      offset == OFS_EVENT_SET || offset == OFS_EVENT_CLEAR ||
      offset == OFS_MASK_SET || offset == OFS_MASK_CLEAR ||
      offset == OFS_ISO_EVENT_SET || offset == OFS_ISO_EVENT_CLEAR ||
      offset == OFS_ISO_MASK_SET || offset == OFS_ISO_MASK_CLEAR);
   assign access_done = psel && penable && pready;
   assign write_ok = access_done && pwrite && !pslverr;

   // Write strobes per register
   assign wr_event_set = write_ok && (offset == OFS_EVENT_SET);
   assign wr_event_clear = write_ok && (offset == OFS_EVENT_CLEAR);
   assign wr_mask_set = write_ok && (offset == OFS_MASK_SET);
   assign wr_mask_clear = write_ok && (offset == OFS_MASK_CLEAR);
   assign wr_iso_event_set = write_ok && (offset == OFS_ISO_EVENT_SET);
   assign wr_iso_event_clear = write_ok && (offset == OFS_ISO_EVENT_CLEAR);
   assign wr_iso_mask_set = write_ok && (offset == OFS_ISO_MASK_SET);
   assign wr_iso_mask_clear = write_ok && (offset == OFS_ISO_MASK_CLEAR);

   // Software set and clear words
   assign sw_set = wr_event_set ? pwdata : 32'h00000000;
   assign sw_clear = wr_event_clear ? pwdata : 32'h00000000;
   assign iso_sw_set =
      wr_iso_event_set ? pwdata[ISO_RX_CONTEXTS-1:0] : '0;
   assign iso_sw_clear =
      wr_iso_event_clear ? pwdata[ISO_RX_CONTEXTS-1:0] : '0;

   // Link clock still missing at the end of the wait
   assign timed_out = mapped && !stable[SRC_LINK_CLOCK_OK] &&
      (wait_count == ACCESS_TIMEOUT_COUNT);

   // Lost cycle tracking between boundaries
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_state <= CY_IDLE;
      end else if (toggle[SRC_CYCLE_LSB]) begin
         cycle_state <= CY_WAIT;
      end else if (rise[SRC_CYCLE_START]) begin
         cycle_state <= CY_MET;
      end else begin
         case (cycle_state)
            CY_WAIT: begin
               if (rise[SRC_ARB_RESET_GAP]) begin
                  cycle_state <= CY_MET;
               end else if (rise[SRC_SUBACTION_GAP]) begin
                  cycle_state <= CY_GAP;
               end
            end
            CY_GAP: begin
               if (rise[SRC_ARB_RESET_GAP] || rise[SRC_SUBACTION_GAP]) begin
                  cycle_state <= CY_MET;
               end
            end
            CY_IDLE: cycle_state <= CY_IDLE;
            CY_MET: cycle_state <= CY_MET;
            default: cycle_state <= CY_IDLE;
         endcase
      end
   end

   always_comb begin
      lost_cycle_hit = 1'b0;
      // (R1) boundary without start
      if (toggle[SRC_CYCLE_LSB] && !rise[SRC_CYCLE_START] &&
          (cycle_state == CY_WAIT || cycle_state == CY_GAP)) begin
         lost_cycle_hit = 1'b1;
      end
      // (R2) predicted from gaps
      if (!rise[SRC_CYCLE_START] && !toggle[SRC_CYCLE_LSB] &&
          ((cycle_state == CY_WAIT && rise[SRC_ARB_RESET_GAP]) ||
           (cycle_state == CY_GAP &&
            (rise[SRC_ARB_RESET_GAP] || rise[SRC_SUBACTION_GAP])))) begin
         lost_cycle_hit = 1'b1;
      end
   end

   // Hardware event sources
   always_comb begin
      hw_set = 32'h00000000;
      hw_clear = 32'h00000000;
      hw_set[BIT_LOST_CYCLE] = lost_cycle_hit;
      // (R3) seconds bit change
      hw_set[BIT_SIXTY_FOUR] = toggle[SRC_SECONDS_BIT];
      // (R4) cycle count toggle
      hw_set[BIT_CYCLE_BOUNDARY] = toggle[SRC_CYCLE_LSB];
      // (R5) PHY status request
      hw_set[BIT_PHY_REQUEST] = rise[SRC_PHY_REQUEST];
      // (R6) failed access flag
      hw_set[BIT_ACCESS_FAILURE] = access_fail;
      // (R7) bus reset entry
      hw_set[BIT_BUS_RESET] = rise[SRC_BUS_RESET];
      // (R8) self-ID done and reset clear
      hw_set[BIT_PRIMARY_SELFID] = rise[SRC_SELFID_DONE];
      hw_clear[BIT_PRIMARY_SELFID] = rise[SRC_BUS_RESET];
      // (R9) secondary follows primary
      hw_set[BIT_SECONDARY_SELFID] = rise[SRC_SELFID_DONE];
      // (R11) lock response not acked
      hw_set[BIT_LOCK_RESPONSE] = rise[SRC_LOCK_NO_ACK];
      // (R12) posted write bus error
      hw_set[BIT_POSTED_WRITE] = rise[SRC_POSTED_ERROR];
   end

   // (R15) event set and clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_bits <= EVENT_RESET;
      end else begin
         event_bits <= ((event_bits
            & ~sw_clear
            & ~hw_clear)
            | hw_set
            | sw_set)
            & EVENT_STORED;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_bits <= MASK_RESET;
      end else if (wr_mask_set) begin
         mask_bits <= (mask_bits | pwdata) & MASK_STORED;
      end else if (wr_mask_clear) begin
         mask_bits <= mask_bits & ~pwdata & MASK_STORED;
      end
   end

   // (R14) per-context receive events
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iso_event <= '0;
      end else begin
         iso_event <= (iso_event
            & ~iso_sw_clear)
            | rise[SRC_ISO_BASE +: ISO_RX_CONTEXTS]
            | iso_sw_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iso_mask <= '0;
      end else if (wr_iso_mask_set) begin
         iso_mask <= iso_mask | pwdata[ISO_RX_CONTEXTS-1:0];
      end else if (wr_iso_mask_clear) begin
         iso_mask <= iso_mask & ~pwdata[ISO_RX_CONTEXTS-1:0];
      end
   end

   // (R13) unlatched receive summary
   assign iso_receive_summary = |(iso_event & iso_mask);

   // (R10) reserved bits stay zero
   always_comb begin
      event_view = event_bits;
      event_view[BIT_ISO_SUMMARY] = iso_receive_summary;
      event_view = event_view & EVENT_READABLE;
   end

   always_comb begin
      case (offset)
         // (R16) event read is masked
         OFS_EVENT_SET, OFS_EVENT_CLEAR: read_value = event_view & mask_bits;
         OFS_MASK_SET, OFS_MASK_CLEAR: read_value = mask_bits;
         OFS_ISO_EVENT_SET, OFS_ISO_EVENT_CLEAR:
            read_value = {{(32-ISO_RX_CONTEXTS){1'b0}}, iso_event};
         OFS_ISO_MASK_SET, OFS_ISO_MASK_CLEAR:
            read_value = {{(32-ISO_RX_CONTEXTS){1'b0}}, iso_mask};
         default: read_value = 32'h00000000;
      endcase
   end

   // (R18) bounded wait for link clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_state <= BUS_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (psel && !penable) begin
                  bus_state <= BUS_WAIT;
               end
            end
            BUS_WAIT: begin
               if (!mapped) begin
                  pready <= 1'b1;
                  pslverr <= 1'b1;
                  prdata <= 32'h00000000;
                  bus_state <= BUS_DONE;
               end else if (stable[SRC_LINK_CLOCK_OK]) begin
                  pready <= 1'b1;
                  pslverr <= 1'b0;
                  prdata <= pwrite ? 32'h00000000 : read_value;
                  bus_state <= BUS_DONE;
               end else if (timed_out) begin
                  pready <= 1'b1;
                  pslverr <= 1'b1;
                  prdata <= 32'h00000000;
                  bus_state <= BUS_DONE;
               end
            end
            BUS_DONE: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               bus_state <= BUS_IDLE;
            end
            default: bus_state <= BUS_IDLE;
         endcase
      end
   end

   // Cycles spent waiting for the link clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_count <= 8'h00;
      end else if (bus_state == BUS_WAIT) begin
         wait_count <= wait_count + 8'h01;
      end else begin
         wait_count <= 8'h00;
      end
   end

   // (R6) fail flagged with the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         access_fail <= 1'b0;
      end else begin
         access_fail <= (bus_state == BUS_WAIT) && timed_out;
      end
   end

   // (R17) master enable gates interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt <= 1'b0;
      end else begin
         interrupt <= mask_bits[BIT_MASTER_ENABLE] &&
            |(event_view & mask_bits & EVENT_READABLE);
      end
   end

endmodule
`default_nettype wire

//--- include/link_irq_pkg.sv
/*
 * Constants for the link interrupt event sources block: register offsets,
 * event bit positions, reset values and the access timeout.
 * Assumes a 32-bit APB register bus clocked at 200 MHz.
 */
package link_irq_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_EVENT_SET = 8'h80;
   localparam logic [7:0] OFS_EVENT_CLEAR = 8'h84;
   localparam logic [7:0] OFS_MASK_SET = 8'h88;
   localparam logic [7:0] OFS_MASK_CLEAR = 8'h8C;
   localparam logic [7:0] OFS_ISO_EVENT_SET = 8'hA0;
   localparam logic [7:0] OFS_ISO_EVENT_CLEAR = 8'hA4;
   localparam logic [7:0] OFS_ISO_MASK_SET = 8'hA8;
   localparam logic [7:0] OFS_ISO_MASK_CLEAR = 8'hAC;

   // Event bit positions
   localparam int BIT_MASTER_ENABLE = 31;
   localparam int BIT_LOST_CYCLE = 22;
   localparam int BIT_SIXTY_FOUR = 21;
   localparam int BIT_CYCLE_BOUNDARY = 20;
   localparam int BIT_PHY_REQUEST = 19;
   localparam int BIT_ACCESS_FAILURE = 18;
   localparam int BIT_BUS_RESET = 17;
   localparam int BIT_PRIMARY_SELFID = 16;
   localparam int BIT_SECONDARY_SELFID = 15;
   localparam int BIT_LOCK_RESPONSE = 9;
   localparam int BIT_POSTED_WRITE = 8;
   localparam int BIT_ISO_SUMMARY = 7;

   // Storable event bits; 14..10 stay zero
   localparam logic [31:0] EVENT_STORED = 32'h007F8300;
   localparam logic [31:0] EVENT_READABLE = 32'h007F8380;
   localparam logic [31:0] MASK_STORED = 32'h807F8380;

   // Reset values
   localparam logic [31:0] EVENT_RESET = 32'h00000000;
   localparam logic [31:0] MASK_RESET = 32'h00000000;

   // Isochronous receive contexts
   localparam int ISO_RX_CONTEXTS = 4;

   // Source vector layout
   localparam int SRC_CYCLE_LSB = 0;
   localparam int SRC_SECONDS_BIT = 1;
   localparam int SRC_CYCLE_START = 2;
   localparam int SRC_SUBACTION_GAP = 3;
   localparam int SRC_ARB_RESET_GAP = 4;
   localparam int SRC_PHY_REQUEST = 5;
   localparam int SRC_BUS_RESET = 6;
   localparam int SRC_SELFID_DONE = 7;
   localparam int SRC_LOCK_NO_ACK = 8;
   localparam int SRC_POSTED_ERROR = 9;
   localparam int SRC_LINK_CLOCK_OK = 10;
   localparam int SRC_ISO_BASE = 11;
   localparam int SRC_COUNT = SRC_ISO_BASE + ISO_RX_CONTEXTS;

   // Link clock wait before a register access fails
   localparam int CLK_PERIOD_NS = 5;
   localparam int ACCESS_TIMEOUT_NS = 1000;
   localparam int ACCESS_TIMEOUT_CYCLES = ACCESS_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam logic [7:0] ACCESS_TIMEOUT_COUNT =
      8'(ACCESS_TIMEOUT_CYCLES - 1);

endpackage

//--- testbench/link_interrupt_event_sources_tb_top.sv
/* Self-checking bench for the link interrupt event block.
   Drives APB; link side events come from the partner model. */
`timescale 1ns/10ps
`default_nettype none
module link_interrupt_event_sources_tb_top
   import link_irq_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, interrupt, err;
   logic [31:0] paddr, pwdata, prdata, rdat;
   logic cycle_count_lsb, cycle_seconds_bit6, cycle_start_seen;
   logic subaction_gap, arb_reset_gap, phy_interrupt_request;
   logic phy_bus_reset, selfid_stream_done, lock_response_no_ack;
   logic posted_write_bus_error, link_clock_ok;
   logic [ISO_RX_CONTEXTS-1:0] iso_receive_context_event;
   int bad_count = 0;
   int total_checks = 0;
   int srcs[4] = '{SRC_PHY_REQUEST, SRC_LOCK_NO_ACK, SRC_POSTED_ERROR,
      SRC_SECONDS_BIT};
   int bits[4] = '{BIT_PHY_REQUEST, BIT_LOCK_RESPONSE, BIT_POSTED_WRITE,
      BIT_SIXTY_FOUR};

   always #2.5 pclk = ~pclk;

   link_interrupt_event_sources i_link_interrupt_event_sources (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cycle_count_lsb, .cycle_seconds_bit6,
      .cycle_start_seen, .subaction_gap, .arb_reset_gap,
      .phy_interrupt_request, .phy_bus_reset, .selfid_stream_done,
      .lock_response_no_ack, .posted_write_bus_error, .link_clock_ok,
      .iso_receive_context_event, .interrupt);

   phy_link_model i_phy_link_model (
      .pclk, .cycle_count_lsb, .cycle_seconds_bit6, .cycle_start_seen,
      .subaction_gap, .arb_reset_gap, .phy_interrupt_request,
      .phy_bus_reset, .selfid_stream_done, .lock_response_no_ack,
      .posted_write_bus_error, .link_clock_ok, .iso_receive_context_event);

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {24'h000000, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 400);
      if (n >= 400) bad_count++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rdat, err);
      chk(32'(err), 32'h00000000);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h00000000, rdat, err);
      chk(rdat, x);
   endtask

   task clr;
      wr(OFS_EVENT_CLEAR, 32'hFFFFFFFF);
   endtask

   task irq(input logic x);
      repeat (2) @(posedge pclk);
      chk(32'(interrupt), 32'(x));
   endtask

   task test_done;
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      test_done;
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h00000000;
      pwdata = 32'h00000000;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      rd(OFS_EVENT_SET, 32'h00000000);
      rd(OFS_MASK_SET, 32'h00000000);
      apb(1'b0, 8'h90, 32'h00000000, rdat, err);
      chk(32'(err), 32'h00000001);
      $display("Test reset done");
      wr(OFS_MASK_SET, 32'hFFFFFFFF);
      rd(OFS_MASK_CLEAR, 32'h807F8380);
      wr(OFS_EVENT_SET, 32'hFFFFFFFF);
      rd(OFS_EVENT_CLEAR, 32'h007F8300);
      irq(1'b1);
      wr(OFS_MASK_CLEAR, 32'h80000000);
      irq(1'b0);
      wr(OFS_MASK_SET, 32'h80000000);
      clr;
      rd(OFS_EVENT_SET, 32'h00000000);
      irq(1'b0);
      $display("Test set_clear done");
      for (int i = 0; i < 4; i++) begin
         i_phy_link_model.pulse(srcs[i]);
         rd(OFS_EVENT_SET, 32'h00000001 << bits[i]);
         clr;
      end
      i_phy_link_model.pulse(SRC_SELFID_DONE);
      rd(OFS_EVENT_SET, 32'h00018000);
      i_phy_link_model.pulse(SRC_BUS_RESET);
      rd(OFS_EVENT_SET, 32'h00028000);
      clr;
      $display("Test sources done");
      i_phy_link_model.flip(SRC_CYCLE_LSB);
      rd(OFS_EVENT_SET, 32'h00100000);
      clr;
      i_phy_link_model.pulse(SRC_CYCLE_START);
      i_phy_link_model.flip(SRC_CYCLE_LSB);
      rd(OFS_EVENT_SET, 32'h00100000);
      clr;
      i_phy_link_model.flip(SRC_CYCLE_LSB);
      rd(OFS_EVENT_SET, 32'h00500000);
      clr;
      i_phy_link_model.pulse(SRC_ARB_RESET_GAP);
      rd(OFS_EVENT_SET, 32'h00400000);
      clr;
      i_phy_link_model.flip(SRC_CYCLE_LSB);
      i_phy_link_model.pulse(SRC_SUBACTION_GAP);
      rd(OFS_EVENT_SET, 32'h00100000);
      i_phy_link_model.pulse(SRC_SUBACTION_GAP);
      rd(OFS_EVENT_SET, 32'h00500000);
      clr;
      $display("Test cycle done");
      wr(OFS_ISO_MASK_SET, 32'h0000000F);
      i_phy_link_model.pulse(SRC_ISO_BASE + 2);
      rd(OFS_ISO_EVENT_SET, 32'h00000004);
      rd(OFS_EVENT_SET, 32'h00000080);
      wr(OFS_ISO_MASK_CLEAR, 32'h0000000F);
      rd(OFS_EVENT_SET, 32'h00000000);
      wr(OFS_ISO_EVENT_CLEAR, 32'h0000000F);
      rd(OFS_ISO_EVENT_CLEAR, 32'h00000000);
      $display("Test iso done");
      wr(OFS_EVENT_SET, 32'h00080000);
      wr(OFS_MASK_CLEAR, 32'h00080000);
      rd(OFS_EVENT_SET, 32'h00000000);
      irq(1'b0);
      wr(OFS_MASK_SET, 32'h00080000);
      rd(OFS_EVENT_SET, 32'h00080000);
      clr;
      i_phy_link_model.flip(SRC_LINK_CLOCK_OK);
      apb(1'b1, OFS_MASK_CLEAR, 32'hFFFFFFFF, rdat, err);
      chk(32'(err), 32'h00000001);
      i_phy_link_model.flip(SRC_LINK_CLOCK_OK);
      rd(OFS_EVENT_SET, 32'h00040000);
      rd(OFS_MASK_SET, 32'h807F8380);
      $display("Test access done");
      test_done;
   end
endmodule
`default_nettype wire

//--- testbench/link_irq_checker.sv
/* Checker for the link interrupt event block.
   Bound to the design top; sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module link_irq_checker
   import link_irq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic link_clock_ok,
   input wire logic interrupt
);
   localparam int ANSWER_MAX = 210;
   logic [3:0] ok_hist;

   // Recent link clock presence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ok_hist <= 4'h0;
      end else begin
         ok_hist <= {ok_hist[2:0], link_clock_ok};
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence done_s;
      psel && penable && pready;
   endsequence

   pulse_once_a: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   ready_phase_a: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_data_a: assert property ((done_s ##0 pslverr) |-> prdata == '0)
      else $error("data not zero on error");
   write_data_a: assert property ((done_s ##0 pwrite) |-> prdata == '0)
      else $error("data not zero on write");
   unmapped_err_a: assert property (
      (done_s ##0 (paddr[7:4] == 4'h9)) |-> pslverr)
      else $error("unmapped access not refused");
   reserved_zero_a: assert property (
      (done_s ##0 (!pwrite && paddr[7:0] == OFS_EVENT_SET))
      |-> prdata[14:10] == 5'h00)
      else $error("reserved event bits not zero");
   fast_answer_a: assert property (
      (setup_s ##0 (&ok_hist)) |-> ##2 pready)
      else $error("answer late with link clock present");
   bounded_answer_a: assert property (
      setup_s |-> ##[1:ANSWER_MAX] pready)
      else $error("access never answered");
   master_off_a: assert property (
      (done_s ##0 (pwrite && !pslverr && paddr[7:0] == OFS_MASK_CLEAR
      && pwdata[BIT_MASTER_ENABLE])) |-> ##2 !interrupt [*3])
      else $error("interrupt with master enable off");
endmodule

bind link_interrupt_event_sources link_irq_checker i_link_irq_checker (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .link_clock_ok, .interrupt
);
`default_nettype wire

//--- testbench/phy_link_model.sv
/* Link side model: cycle timer, PHY and DMA event sources.
   Driven by task calls from the bench; one clock. */
`timescale 1ns/10ps
`default_nettype none
module phy_link_model
   import link_irq_pkg::*;
(
   input wire logic pclk,
   output logic cycle_count_lsb,
   output logic cycle_seconds_bit6,
   output logic cycle_start_seen,
   output logic subaction_gap,
   output logic arb_reset_gap,
   output logic phy_interrupt_request,
   output logic phy_bus_reset,
   output logic selfid_stream_done,
   output logic lock_response_no_ack,
   output logic posted_write_bus_error,
   output logic link_clock_ok,
   output logic [ISO_RX_CONTEXTS-1:0] iso_receive_context_event
);
   logic [SRC_COUNT-1:0] src = SRC_COUNT'(1) << SRC_LINK_CLOCK_OK;

   assign cycle_count_lsb = src[SRC_CYCLE_LSB];
   assign cycle_seconds_bit6 = src[SRC_SECONDS_BIT];
   assign cycle_start_seen = src[SRC_CYCLE_START];
   assign subaction_gap = src[SRC_SUBACTION_GAP];
   assign arb_reset_gap = src[SRC_ARB_RESET_GAP];
   assign phy_interrupt_request = src[SRC_PHY_REQUEST];
   assign phy_bus_reset = src[SRC_BUS_RESET];
   assign selfid_stream_done = src[SRC_SELFID_DONE];
   assign lock_response_no_ack = src[SRC_LOCK_NO_ACK];
   assign posted_write_bus_error = src[SRC_POSTED_ERROR];
   assign link_clock_ok = src[SRC_LINK_CLOCK_OK];
   assign iso_receive_context_event = src[SRC_ISO_BASE +: ISO_RX_CONTEXTS];

   task flip(input int b);
      @(posedge pclk);
      src[b] <= ~src[b];
      repeat (6) @(posedge pclk);
   endtask

   task pulse(input int b);
      flip(b);
      flip(b);
   endtask
endmodule
`default_nettype wire
